//--- hdl/prof_pkg.sv
package prof_pkg;
    // Event type codes written into byte 0
    localparam logic [7:0] EVT_VALUE_SAMPLE = 8'h01;
    localparam logic [7:0] EVT_INSN_RETIRED = 8'h02;
    localparam logic [7:0] EVT_BRANCH       = 8'h03;
    // Privilege level that counts as user mode
    localparam logic [1:0] USER_LEVEL       = 2'h3;
    // Flag bit positions inside the 16-bit flags field (bytes 3..2)
    localparam int FLAG_FUSED_POS           = 12;
    localparam int FLAG_PRED_VALID_POS      = 13;
    localparam int FLAG_PRED_OK_POS         = 14;
    localparam int FLAG_TAKEN_POS           = 15;
    // Counter values after reset
    localparam logic [31:0] CNT_RESET       = 32'h0000_0000;
    // Record fifo depth
    localparam int REC_FIFO_DEPTH           = 4;
    localparam int REC_BITS                 = 256;

    // Branch kinds seen at retirement
    typedef enum logic [2:0] {
        BR_NONE     = 3'b000,
        BR_NEAR_JMP = 3'b001,
        BR_COND     = 3'b010,
        BR_CXZ      = 3'b011,
        BR_LOOP     = 3'b100,
        BR_NEAR_CR  = 3'b101,
        BR_FAR      = 3'b110,
        BR_SYSTEM   = 3'b111
    } branch_kind_t;

    // One retiring instruction as the core reports it
    typedef struct packed {
        logic         valid;
        logic [63:0]  address;
        logic [1:0]   priv_before;
        logic [1:0]   priv_after;
        logic         fused;
        logic [63:0]  flag_op_address;
        logic         is_value_sample;
        logic [15:0]  imm;
        logic [31:0]  rm_value;
        logic [63:0]  reg_value;
        logic         legacy_mode;
        branch_kind_t br_kind;
        logic         taken;
        logic         pred_valid;
        logic         pred_ok;
        logic [63:0]  next_address;
    } retire_t;

    // Event record, byte 0 in the low bits
    typedef struct packed {
        logic [63:0] timestamp;
        logic [63:0] aux;
        logic [63:0] insn_addr;
        logic [31:0] data1;
        logic [15:0] flags;
        logic [7:0]  core_id;
        logic [7:0]  event_type_field;
    } record_t;
endpackage

//--- hdl/profiling_event_records.sv
`timescale 1ns/1ps
module profiling_event_records (
    input  wire logic                 mclk_i,
    input  wire logic                 rst_i,
    input  wire prof_pkg::retire_t    retire_i,         // Retirement port
    output logic                      retire_stall_o,   // Hold retirement, record pending
    input  wire logic                 enable_i,         // Profiling running
    input  wire logic                 ts_enable_i,      // Timestamp flag
    input  wire logic [7:0]           core_id_i,        // From profiler_config_reg
    input  wire logic [63:0]          perf_ts_i,        // perf_timestamp_counter
    input  wire logic                 load_sample_i,    // Reload value-sample counter
    input  wire logic                 load_insn_i,      // Reload instructions counter
    input  wire logic                 load_branch_i,    // Reload branch counter
    input  wire logic [31:0]          load_value_i,     // Reload value
    output logic [31:0]               sample_cnt_o,     // Value-sample counter
    output logic [31:0]               insn_cnt_o,       // Instructions counter
    output logic [31:0]               branch_cnt_o,     // Branch counter
    output logic                      rec_valid_o,      // Record ready for memory
    input  wire logic                 rec_ready_i,      // Memory writer accepts
    output prof_pkg::record_t         rec_data_o        // 32-byte record
);
    logic [31:0]          sample_cnt_r;   // Down-counter, value samples
    logic [31:0]          insn_cnt_r;     // Down-counter, retired instructions
    logic [31:0]          branch_cnt_r;   // Down-counter, branches
    logic [31:0]          sample_cnt_nxt; // Next value-sample count
    logic [31:0]          insn_cnt_nxt;   // Next instruction count
    logic [31:0]          branch_cnt_nxt; // Next branch count
    logic                 take;           // Retirement accepted this cycle
    logic                 user_only;      // Wholly at user level
    logic                 br_counted;     // Branch kind that counts
    logic                 br_uncond;      // Unconditional kind
    logic [31:0]          insn_step;      // 1, or 2 when fused
    logic                 fire_sample;    // Sample counter went negative
    logic                 fire_insn;      // Insn counter went negative
    logic                 fire_branch;    // Branch counter went negative
    logic [63:0]          ts_field;       // Timestamp or zero
    logic [63:0]          rep_addr;       // Reported address
    prof_pkg::record_t    rec_sample;     // Built sample record
    prof_pkg::record_t    rec_insn;       // Built instructions record
    prof_pkg::record_t    rec_branch;     // Built branch record
    prof_pkg::record_t    pend_r [3];     // Records waiting for fifo
    logic [2:0]           pend_v_r;       // Pending valid per type
    logic                 fifo_in_valid;  // Offer to fifo
    logic                 fifo_in_ready;  // Fifo has room
    prof_pkg::record_t    fifo_in_data;   // Chosen pending record
    logic [1:0]           sel;            // Pending slot chosen
    logic [255:0]         fifo_out;       // Raw fifo head

    // Stall retirement while any pending slot still holds a record; keeps every overflow record
    assign retire_stall_o = (pend_v_r != 3'b000);
    assign take           = retire_i.valid && enable_i && !retire_stall_o;

    // Privilege qualification
    always_comb begin
        user_only = (retire_i.priv_before == prof_pkg::USER_LEVEL) &&
                    (retire_i.priv_after == prof_pkg::USER_LEVEL);
    end

    // Branch classification
    always_comb begin
        unique case (retire_i.br_kind)
            prof_pkg::BR_NEAR_JMP: br_counted = 1'b1;
            prof_pkg::BR_COND:     br_counted = 1'b1;
            prof_pkg::BR_CXZ:      br_counted = 1'b1;
            prof_pkg::BR_LOOP:     br_counted = 1'b1;
            prof_pkg::BR_NEAR_CR:  br_counted = 1'b1;
            prof_pkg::BR_FAR:      br_counted = 1'b0;
            prof_pkg::BR_SYSTEM:   br_counted = 1'b0;
            prof_pkg::BR_NONE:     br_counted = 1'b0;
        endcase
        // Ring transitions never qualify
        br_counted = br_counted && user_only;
        br_uncond  = (retire_i.br_kind == prof_pkg::BR_NEAR_JMP) ||
                     (retire_i.br_kind == prof_pkg::BR_NEAR_CR);
    end

    // Fused pair was two instructions originally
    assign insn_step = retire_i.fused ? 32'h0000_0002 : 32'h0000_0001;

    // Next counter values and overflow detection
    always_comb begin
        sample_cnt_nxt = sample_cnt_r;
        insn_cnt_nxt   = insn_cnt_r;
        branch_cnt_nxt = branch_cnt_r;
        fire_sample    = 1'b0;
        fire_insn      = 1'b0;
        fire_branch    = 1'b0;
        if (take && user_only) begin
            insn_cnt_nxt = insn_cnt_r - insn_step;
            fire_insn    = !insn_cnt_r[31] && insn_cnt_nxt[31];
        end
        if (take && user_only && retire_i.is_value_sample) begin
            sample_cnt_nxt = sample_cnt_r - 32'h0000_0001;
            fire_sample    = !sample_cnt_r[31] && sample_cnt_nxt[31];
        end
        if (take && br_counted) begin
            branch_cnt_nxt = branch_cnt_r - 32'h0000_0001;
            fire_branch    = !branch_cnt_r[31] && branch_cnt_nxt[31];
        end
    end

    // Counters; a reload wins over a decrement in the same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sample_cnt_r <= prof_pkg::CNT_RESET;
            insn_cnt_r   <= prof_pkg::CNT_RESET;
            branch_cnt_r <= prof_pkg::CNT_RESET;
        end else begin
            sample_cnt_r <= load_sample_i ? load_value_i : sample_cnt_nxt;
            insn_cnt_r   <= load_insn_i   ? load_value_i : insn_cnt_nxt;
            branch_cnt_r <= load_branch_i ? load_value_i : branch_cnt_nxt;
        end
    end

    assign sample_cnt_o = sample_cnt_r;
    assign insn_cnt_o   = insn_cnt_r;
    assign branch_cnt_o = branch_cnt_r;

    // Shared fields
    assign ts_field = ts_enable_i ? perf_ts_i : 64'h0;
    assign rep_addr = retire_i.fused ? retire_i.flag_op_address : retire_i.address;

    // Record assembly; every field starts at zero
    always_comb begin
        rec_sample                  = '0;
        rec_sample.event_type_field = prof_pkg::EVT_VALUE_SAMPLE;
        rec_sample.core_id          = core_id_i;
        rec_sample.flags            = retire_i.imm;
        rec_sample.data1            = retire_i.rm_value;
        rec_sample.insn_addr        = retire_i.address;
        rec_sample.aux              = retire_i.legacy_mode ?
                                      {32'h0, retire_i.reg_value[31:0]} : retire_i.reg_value;
        rec_sample.timestamp        = ts_field;

        rec_insn                  = '0;
        rec_insn.event_type_field = prof_pkg::EVT_INSN_RETIRED;
        rec_insn.core_id          = core_id_i;
        rec_insn.insn_addr        = rep_addr;
        rec_insn.timestamp        = ts_field;

        rec_branch                  = '0;
        rec_branch.event_type_field = prof_pkg::EVT_BRANCH;
        rec_branch.core_id          = core_id_i;
        rec_branch.flags[prof_pkg::FLAG_FUSED_POS]      = retire_i.fused;
        rec_branch.flags[prof_pkg::FLAG_PRED_VALID_POS] = retire_i.pred_valid;
        // Correct bit only carries meaning with valid set; forced low otherwise
        rec_branch.flags[prof_pkg::FLAG_PRED_OK_POS]    = retire_i.pred_valid &&
                                                          (retire_i.pred_ok || br_uncond);
        rec_branch.flags[prof_pkg::FLAG_TAKEN_POS]      = retire_i.taken || br_uncond;
        rec_branch.insn_addr        = rep_addr;
        rec_branch.aux              = retire_i.next_address;
        rec_branch.timestamp        = ts_field;
    end

    // Pending slot selection, lowest type first
    always_comb begin
        sel           = 2'd0;
        fifo_in_valid = 1'b1;
        if (pend_v_r[0]) begin
            sel = 2'd0;
        end else if (pend_v_r[1]) begin
            sel = 2'd1;
        end else if (pend_v_r[2]) begin
            sel = 2'd2;
        end else begin
            fifo_in_valid = 1'b0;
        end
        fifo_in_data = pend_r[sel];
    end

    // Pending records per type; one retirement may fire several
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pend
            logic fire_i;
            assign fire_i = (i == 0) ? fire_sample : ((i == 1) ? fire_insn : fire_branch);
            always_ff @(posedge mclk_i) begin
                if (rst_i) begin
                    pend_v_r[i] <= 1'b0;
                    pend_r[i]   <= '0;
                end else if (fire_i) begin
                    pend_v_r[i] <= 1'b1;
                    pend_r[i]   <= (i == 0) ? rec_sample : ((i == 1) ? rec_insn : rec_branch);
                end else if (fifo_in_valid && fifo_in_ready && sel == 2'(i)) begin
                    pend_v_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Record fifo toward the ring-buffer writer
    rec_fifo #(
        .WIDTH (prof_pkg::REC_BITS),
        .DEPTH (prof_pkg::REC_FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (fifo_in_data),
        .out_valid_o (rec_valid_o),
        .out_ready_i (rec_ready_i),
        .out_data_o  (fifo_out)
    );

    assign rec_data_o = prof_pkg::record_t'(fifo_out);
endmodule

//--- hdl/rec_fifo.sv
`timescale 1ns/1ps
// Small synchronous FIFO, head read straight from the storage array
module rec_fifo #(
    parameter int WIDTH = 256,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];    // Storage
    logic [AW-1:0]    wr_ptr_r;         // Write index
    logic [AW-1:0]    rd_ptr_r;         // Read index
    logic [AW:0]      count_r;          // Words held in storage
    logic             push;             // Accepted write
    logic             pop;              // Accepted read

    assign in_ready_o  = (count_r != (AW+1)'(DEPTH)); // Room while below depth
    assign out_valid_o = (count_r != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage write
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Head word, combinational view of the registered array
    assign out_data_o = mem_r[rd_ptr_r];
endmodule

//--- tb/prof_records_asserts.sv
`timescale 1ns/1ps
// Counting and record checks, top ports only
module prof_records_chk (
    input wire logic              mclk_i,
    input wire logic              rst_i,
    input wire prof_pkg::retire_t retire_i,
    input wire logic              retire_stall_o,
    input wire logic              enable_i,
    input wire logic              ts_enable_i,
    input wire logic              load_sample_i,
    input wire logic              load_insn_i,
    input wire logic              load_branch_i,
    input wire logic [31:0]       sample_cnt_o,
    input wire logic [31:0]       insn_cnt_o,
    input wire logic [31:0]       branch_cnt_o,
    input wire logic              rec_valid_o,
    input wire logic              rec_ready_i,
    input wire prof_pkg::record_t rec_data_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic tk;   // Retirement taken this edge
    logic usr;  // Wholly user level
    logic brk;  // Counted branch kind
    assign tk  = retire_i.valid && enable_i && !retire_stall_o;
    assign usr = retire_i.priv_before == prof_pkg::USER_LEVEL && retire_i.priv_after == prof_pkg::USER_LEVEL;
    assign brk = retire_i.br_kind inside {[prof_pkg::BR_NEAR_JMP:prof_pkg::BR_NEAR_CR]};
    logic ts_clean_r; // Nothing in flight was built with the timestamp on
    // Cleared by the flag; set again only once pending slots and fifo are empty
    always_ff @(posedge mclk_i) begin
        ts_clean_r <= !ts_enable_i && (ts_clean_r || rst_i || (!rec_valid_o && !retire_stall_o));
    end
    // Counter at zero about to wrap: overflow step then stall
    sequence s_fire;
        tk && usr && insn_cnt_o == 32'h0 && !load_insn_i;
    endsequence
    sequence s_step;
        tk && usr && !load_insn_i;
    endsequence
    chk_insn_step: assert property (
        s_step and !retire_i.fused |=> insn_cnt_o == $past(insn_cnt_o) - 32'h1)
        else $error("insn counter did not step by one");
    chk_insn_fused: assert property (s_step and retire_i.fused |=> insn_cnt_o == $past(insn_cnt_o) - 32'h2)
        else $error("fused op did not step insn counter by two");
    chk_insn_foreign: assert property (tk && !usr && !load_insn_i |=> $stable(insn_cnt_o))
        else $error("non-user insn counted");
    chk_branch_step: assert property (
        tk && usr && brk && !load_branch_i |=> branch_cnt_o == $past(branch_cnt_o) - 32'h1)
        else $error("branch counter did not step");
    chk_branch_skip: assert property (tk && !(usr && brk) && !load_branch_i |=> $stable(branch_cnt_o))
        else $error("uncounted transfer changed branch counter");
    chk_sample_step: assert property (
        tk && usr && retire_i.is_value_sample && !load_sample_i |=> sample_cnt_o == $past(sample_cnt_o) - 32'h1)
        else $error("sample counter did not step");
    chk_fire_stall: assert property (s_fire |=> retire_stall_o)
        else $error("overflow raised no pending record");
    chk_rec_hold: assert property (rec_valid_o && !rec_ready_i |=> rec_valid_o && $stable(rec_data_o))
        else $error("record dropped or changed while waiting");
    chk_ts_off: assert property (rec_valid_o && ts_clean_r |-> rec_data_o.timestamp == 64'h0)
        else $error("timestamp written while disabled");
    chk_insn_rsvd: assert property (rec_valid_o && rec_data_o.event_type_field == prof_pkg::EVT_INSN_RETIRED |->
        rec_data_o.flags == 16'h0 && rec_data_o.data1 == 32'h0 && rec_data_o.aux == 64'h0)
        else $error("insn record reserved field not zero");
    chk_branch_rsvd: assert property (rec_valid_o && rec_data_o.event_type_field == prof_pkg::EVT_BRANCH |->
        rec_data_o.flags[11:0] == 12'h0 && rec_data_o.data1 == 32'h0)
        else $error("branch record reserved field not zero");
endmodule
bind profiling_event_records prof_records_chk prof_records_chk_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .retire_i(retire_i), .retire_stall_o(retire_stall_o), .enable_i(enable_i), .ts_enable_i(ts_enable_i),
    .load_sample_i(load_sample_i), .load_insn_i(load_insn_i), .load_branch_i(load_branch_i),
    .sample_cnt_o(sample_cnt_o), .insn_cnt_o(insn_cnt_o), .branch_cnt_o(branch_cnt_o),
    .rec_valid_o(rec_valid_o), .rec_ready_i(rec_ready_i), .rec_data_o(rec_data_o));

//--- tb/ring_sink.sv
`timescale 1ns/1ps
// Memory ring writer: accepts records, can stall or refuse
module ring_sink (
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              hold_i,      // Refuse everything
    input  wire logic              slow_i,      // Accept every other cycle
    input  wire logic              rec_valid_i,
    output logic                   rec_ready_o,
    input  wire prof_pkg::record_t rec_data_i,
    output prof_pkg::record_t      last_o,      // Last stored record
    output int                     count_o      // Records stored
);
    logic phase_r;  // Alternating acceptance slot
    always_ff @(posedge mclk_i) begin
        phase_r <= rst_i ? 1'b0 : ~phase_r;
    end
    assign rec_ready_o = !hold_i && (!slow_i || phase_r);
    // Store on handshake only
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            count_o <= 0;
        end else if (rec_valid_i && rec_ready_o) begin
            count_o <= count_o + 1;
            last_o  <= rec_data_i;
        end
    end
endmodule

//--- tb/tb_profiling_event_records.sv
`timescale 1ns/1ps
// Self-checking bench: table of retirements, then reset and buffer cases
module tb_profiling_event_records;
    typedef struct packed {
        prof_pkg::retire_t r;   // Retirement to apply
        logic [1:0]        sel; // Counter armed at zero
        logic              ts;  // Timestamp flag
    } row_t;
    logic              mclk = 1'b0, rst = 1'b1, en = 1'b1, ts_en = 1'b0, hold = 1'b0, slow = 1'b0;
    logic              ld_s = 1'b0, ld_i = 1'b0, ld_b = 1'b0, stall, rvalid, rready;
    logic [7:0]        cid = 8'h00;
    logic [31:0]       ld_v = 32'h0, cnt [1:3], e32;
    logic [63:0]       pts = 64'h0;
    prof_pkg::retire_t ret = '0, rr;
    prof_pkg::record_t rdat, last;
    row_t              rows [14];
    int                n_fail = 0, n_compared = 0, got, base, k;
    always #5 mclk = ~mclk;
    profiling_event_records profiling_event_records_i (.mclk_i(mclk), .rst_i(rst), .retire_i(ret),
        .retire_stall_o(stall), .enable_i(en), .ts_enable_i(ts_en), .core_id_i(cid), .perf_ts_i(pts),
        .load_sample_i(ld_s), .load_insn_i(ld_i), .load_branch_i(ld_b), .load_value_i(ld_v),
        .sample_cnt_o(cnt[1]), .insn_cnt_o(cnt[2]), .branch_cnt_o(cnt[3]), .rec_valid_o(rvalid),
        .rec_ready_i(rready), .rec_data_o(rdat));
    ring_sink ring_sink_i (.mclk_i(mclk), .rst_i(rst), .hold_i(hold), .slow_i(slow), .rec_valid_i(rvalid),
        .rec_ready_o(rready), .rec_data_i(rdat), .last_o(last), .count_o(got));
    function automatic prof_pkg::retire_t mk(prof_pkg::branch_kind_t kd, logic [3:0] p, logic vs, fu, tk, lg);
        mk = '0;
        mk = '{1'b1, 64'h0000_7f12_3456_7000, p[3:2], p[1:0], fu, 64'h0000_7f12_3456_6ffc, vs, 16'hbeef,
            32'hc0de_1234, 64'hfedc_ba98_7654_3210, lg, kd, tk, !fu, tk, 64'h0000_7f12_3456_8000};
    endfunction
    // Decrement a retirement should cause on counter k
    function automatic logic [31:0] dec(prof_pkg::retire_t r, int k);
        if (r.priv_before != prof_pkg::USER_LEVEL || r.priv_after != prof_pkg::USER_LEVEL) return 32'h0;
        if (k == 1) return {31'h0, r.is_value_sample};
        if (k == 2) return r.fused ? 32'h2 : 32'h1;
        return (r.br_kind inside {[prof_pkg::BR_NEAR_JMP:prof_pkg::BR_NEAR_CR]}) ? 32'h1 : 32'h0;
    endfunction
    // Record expected from the layout of each event type
    function automatic prof_pkg::record_t exp_rec(row_t w);
        prof_pkg::retire_t r;
        logic              uc;
        r = w.r;
        // Near jumps, calls and returns are the unconditional kinds
        uc = r.br_kind inside {prof_pkg::BR_NEAR_JMP, prof_pkg::BR_NEAR_CR};
        exp_rec = '0;
        exp_rec.event_type_field = {6'h0, w.sel};
        exp_rec.core_id = cid;
        exp_rec.timestamp = w.ts ? pts : 64'h0;
        exp_rec.insn_addr = (w.sel == 2'h3 && r.fused) ? r.flag_op_address : r.address;
        if (w.sel == 2'h1) begin
            exp_rec.flags = r.imm;
            exp_rec.data1 = r.rm_value;
            exp_rec.aux = r.legacy_mode ? {32'h0, r.reg_value[31:0]} : r.reg_value;
        end else if (w.sel == 2'h3) begin
            exp_rec.flags[prof_pkg::FLAG_FUSED_POS] = r.fused;
            exp_rec.flags[prof_pkg::FLAG_PRED_VALID_POS] = r.pred_valid;
            exp_rec.flags[prof_pkg::FLAG_PRED_OK_POS] = r.pred_valid && (r.pred_ok || uc);
            exp_rec.flags[prof_pkg::FLAG_TAKEN_POS] = r.taken || uc;
            exp_rec.aux = r.next_address;
        end
    endfunction
    task automatic chk(input string nm, input logic [255:0] e, input logic [255:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Load all counters to 16, then the armed one to v
    task automatic arm(input logic [1:0] sel, input logic [31:0] v);
        ld_v <= 32'h10; ld_s <= 1'b1; ld_i <= 1'b1; ld_b <= 1'b1;
        @(posedge mclk);
        ld_v <= v; ld_s <= sel == 2'h1; ld_i <= sel == 2'h2; ld_b <= sel == 2'h3;
        @(posedge mclk);
        ld_s <= 1'b0; ld_i <= 1'b0; ld_b <= 1'b0;
    endtask
    // Hold the retirement until an edge with no stall takes it
    task automatic retire_one(input prof_pkg::retire_t r);
        logic s;
        ret <= r;
        for (int j = 0; j < 40; j++) begin
            @(negedge mclk) s = stall;
            @(posedge mclk);
            if (!s) break;
        end
        ret <= '0;
    endtask
    initial begin
        #200000 n_fail++;
        test_done();
    end
    initial begin
        rows = '{'{mk(prof_pkg::BR_NONE, 4'hf, 1, 0, 0, 0), 2'h1, 1'b1},
            '{mk(prof_pkg::BR_NONE, 4'hf, 1, 0, 0, 1), 2'h1, 1'b0},
            '{mk(prof_pkg::BR_NONE, 4'hf, 0, 0, 0, 0), 2'h2, 1'b1},
            '{mk(prof_pkg::BR_NONE, 4'h3, 0, 0, 0, 0), 2'h2, 1'b0},
            '{mk(prof_pkg::BR_NONE, 4'h0, 0, 0, 0, 0), 2'h2, 1'b0},
            '{mk(prof_pkg::BR_NEAR_JMP, 4'hf, 0, 0, 0, 0), 2'h3, 1'b1},
            '{mk(prof_pkg::BR_COND, 4'hf, 0, 0, 0, 0), 2'h3, 1'b0},
            '{mk(prof_pkg::BR_COND, 4'hf, 0, 1, 1, 0), 2'h3, 1'b1},
            '{mk(prof_pkg::BR_CXZ, 4'hf, 0, 0, 1, 0), 2'h3, 1'b0},
            '{mk(prof_pkg::BR_LOOP, 4'hf, 0, 0, 1, 0), 2'h3, 1'b0},
            '{mk(prof_pkg::BR_NEAR_CR, 4'hf, 0, 0, 0, 0), 2'h3, 1'b0},
            '{mk(prof_pkg::BR_FAR, 4'hf, 0, 0, 1, 0), 2'h3, 1'b0},
            '{mk(prof_pkg::BR_SYSTEM, 4'hf, 0, 0, 1, 0), 2'h3, 1'b0},
            '{mk(prof_pkg::BR_COND, 4'hc, 0, 0, 1, 0), 2'h3, 1'b0}};
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk) #1;
        chk("reset_cnt", 256'h0, {cnt[1], cnt[2], cnt[3]});
        chk("reset_out", 256'h0, {rvalid, stall});
        for (int i = 0; i < 14; i++) begin
            slow <= i[0]; ts_en <= rows[i].ts; cid <= 8'h40 + 8'(i); pts <= 64'h0000_1234_0000_0000 + 64'(i);
            arm(rows[i].sel, 32'h0);
            base = got;
            retire_one(rows[i].r);
            repeat (12) @(posedge mclk);
            #1;
            for (int c = 1; c < 4; c++) begin
                // Kept at 32 bits so that a wrap below zero compares as the counter shows it
                e32 = (c == rows[i].sel ? 32'h0 : 32'h10) - dec(rows[i].r, c);
                chk("counter", 256'(e32), 256'(cnt[c]));
            end
            chk("rec_count", 256'(base + (dec(rows[i].r, rows[i].sel) != 0)), 256'(got));
            if (got != base)
                chk("record", exp_rec(rows[i]), last);
        end
        arm(2'h2, 32'h5);
        retire_one(mk(prof_pkg::BR_COND, 4'hf, 0, 1, 1, 0));
        en <= 1'b0;
        @(posedge mclk);
        retire_one(mk(prof_pkg::BR_NONE, 4'hf, 0, 0, 0, 0));
        #1 chk("fused_cnt", 256'h3, 256'(cnt[2]));
        en <= 1'b1; hold <= 1'b1; ts_en <= 1'b0; base = got;
        for (int i = 0; i < 5; i++) begin
            arm(2'h2, 32'h0);
            rr = mk(prof_pkg::BR_NONE, 4'hf, 0, 0, 0, 0);
            rr.address = 64'h100 + 64'(i);
            retire_one(rr);
        end
        repeat (3) @(posedge mclk);
        #1 chk("full_stall", 256'h3, {rvalid, stall});
        hold <= 1'b0;
        for (k = 0; k < 40 && got != base + 5; k++) @(posedge mclk);
        #1 chk("drained", 256'(base + 5), 256'(got));
        chk("drain_last", 256'h104, 256'(last.insn_addr));
        // Reset in mid-run drops a queued record and clears the counters
        hold <= 1'b1;
        arm(2'h2, 32'h0);
        retire_one(mk(prof_pkg::BR_NONE, 4'hf, 0, 0, 0, 0));
        repeat (3) @(posedge mclk);
        #1 chk("pre_reset", 256'h1, 256'(rvalid));
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        hold <= 1'b0;
        @(posedge mclk) #1;
        chk("mid_reset", 256'h0, {rvalid, stall, cnt[1], cnt[2], cnt[3]});
        test_done();
    end
endmodule
